/* design/interrupt_vector_priority.v */
// Interrupt vector and priority logic: latches source requests, arbitrates
// by fixed priority and hands one vector offset to the program sequencer.
// Assumes on-chip sources give one-cycle pulses in the clk_sys domain and
// the sequencer answers each request with a one-cycle acknowledge.
//
// Overview of operation
// - Hardware and software reset vector to offset 00 at priority 1.
// - Each source has a fixed offset; NMI 04/2, timer 4C/6, host 64/12.
// - External pin zero vectors to 40 at priority 3.
// - External pin one vectors to 44 at priority 4.
// - External pin two vectors to 48 at priority 5.
// - External pin three vectors to 60 at priority 11.
// - Port zero receive vectors to 50 at priority 7.
// - Port zero transmit vectors to 54 at priority 8.
// - Port two receive vectors to 58 at priority 9.
// - Port two transmit vectors to 5C at priority 10.
// - Port one receive vectors to 68 at priority 13.
// - Port one transmit vectors to 6C at priority 14.
// - DMA channel four vectors to 70 at priority 15.
// - DMA channel five vectors to 74 at priority 16, lowest.
// - Software traps 17..30 use slots 08..3C at priority 0, taken after all other ready sources; 78..7F unused.
`timescale 1ns/1ps
`include "irq_vector_map.vh"
`default_nettype none
module interrupt_vector_priority (
  input wire clk_sys,
  input wire reset_n,
  input wire hw_reset_pin_n,
  input wire soft_reset_trap,
  input wire nmi_pin_n,
  input wire soft_trap_sixteen,
  input wire softTrapValid,
  input wire [3:0] softTrapNumber,
  input wire ext_irq_zero_n,
  input wire ext_irq_one_n,
  input wire ext_irq_two_n,
  input wire ext_irq_three_n,
  input wire timer_irq,
  input wire port0_rx_irq,
  input wire port0_tx_irq,
  input wire port1_rx_irq,
  input wire port1_tx_irq,
  input wire port2_rx_irq,
  input wire port2_tx_irq,
  input wire host_port_irq,
  input wire dma_ch4_irq,
  input wire dma_ch5_irq,
  input wire [`MASKABLE_COUNT-1:0] maskWriteData,
  input wire maskWrite,
  input wire [`MASKABLE_COUNT-1:0] pendingClear,
  input wire globalEnable,
  input wire vectorAck,
  output reg vectorReq,
  output reg [6:0] vectorOffset,
  output reg [4:0] vectorPriority,
  output reg [`MASKABLE_COUNT-1:0] pendingFlags,
  output reg [`MASKABLE_COUNT-1:0] maskFlags
);
  localparam NUM = `MASKABLE_COUNT;
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam KIND_MASK = 2'h0;
  localparam KIND_RESET = 2'h1;
  localparam KIND_NMI = 2'h2;
  localparam KIND_SOFT = 2'h3;

  wire [3:0] extFall;
  wire [1:0] ctlFall;
  reg [1:0] state_reg;
  reg resetPend_reg;
  reg nmiPend_reg;
  reg softPend_reg;
  reg [6:0] softOffset_reg;
  reg [NUM-1:0] pending_reg;
  reg [NUM-1:0] pending_next;
  reg [NUM-1:0] mask_reg;
  reg [NUM-1:0] rawEvent;
  reg [NUM-1:0] granted_reg;
  reg [NUM-1:0] winner;
  reg [6:0] winOffset;
  reg [4:0] winPriority;
  reg winValid;
  reg [1:0] winKind;
  reg [1:0] kind_reg;
  integer k;
  wire ackNow;
  wire softAccept;
  wire [6:0] softSlot;

  // Traps past the last slot would land on hardware vectors
  assign ackNow = (state_reg == ST_WAIT) && vectorAck;
  assign softAccept = softTrapValid && (softTrapNumber <= `SOFT_TRAP_LAST) &&
    !softPend_reg;
  assign softSlot = `VEC_SOFT_FIRST + {1'b0, softTrapNumber, 2'b00};

  irq_sync_edge #(.WIDTH(4)) u_ext_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinLevel_n({ext_irq_three_n, ext_irq_two_n, ext_irq_one_n,
      ext_irq_zero_n}),
    .fallPulse(extFall)
  );

  irq_sync_edge #(.WIDTH(2)) u_ctl_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinLevel_n({nmi_pin_n, hw_reset_pin_n}),
    .fallPulse(ctlFall)
  );

  // Vector offset of a maskable source, by bit position
  function [6:0] vecOf;
    input integer idx;
    begin
      case (idx)
        `BIT_EXT0: vecOf = `VEC_EXT0;
        `BIT_EXT1: vecOf = `VEC_EXT1;
        `BIT_EXT2: vecOf = `VEC_EXT2;
        `BIT_TIMER: vecOf = `VEC_TIMER;
        `BIT_P0RX: vecOf = `VEC_P0RX;
        `BIT_P0TX: vecOf = `VEC_P0TX;
        `BIT_P2RX: vecOf = `VEC_P2RX;
        `BIT_P2TX: vecOf = `VEC_P2TX;
        `BIT_EXT3: vecOf = `VEC_EXT3;
        `BIT_HOST: vecOf = `VEC_HOST;
        `BIT_P1RX: vecOf = `VEC_P1RX;
        `BIT_P1TX: vecOf = `VEC_P1TX;
        `BIT_DMA4: vecOf = `VEC_DMA4;
        default: vecOf = `VEC_DMA5;
      endcase
    end
  endfunction

  // Priority of a maskable source, by bit position
  function [4:0] priOf;
    input integer idx;
    begin
      case (idx)
        `BIT_EXT0: priOf = `PRI_EXT0;
        `BIT_EXT1: priOf = `PRI_EXT1;
        `BIT_EXT2: priOf = `PRI_EXT2;
        `BIT_TIMER: priOf = `PRI_TIMER;
        `BIT_P0RX: priOf = `PRI_P0RX;
        `BIT_P0TX: priOf = `PRI_P0TX;
        `BIT_P2RX: priOf = `PRI_P2RX;
        `BIT_P2TX: priOf = `PRI_P2TX;
        `BIT_EXT3: priOf = `PRI_EXT3;
        `BIT_HOST: priOf = `PRI_HOST;
        `BIT_P1RX: priOf = `PRI_P1RX;
        `BIT_P1TX: priOf = `PRI_P1TX;
        `BIT_DMA4: priOf = `PRI_DMA4;
        default: priOf = `PRI_DMA5;
      endcase
    end
  endfunction

  always @* begin
    rawEvent = {NUM{1'b0}};
    rawEvent[`BIT_EXT0] = extFall[0];
    rawEvent[`BIT_EXT1] = extFall[1];
    rawEvent[`BIT_EXT2] = extFall[2];
    rawEvent[`BIT_EXT3] = extFall[3];
    rawEvent[`BIT_TIMER] = timer_irq;
    rawEvent[`BIT_P0RX] = port0_rx_irq;
    rawEvent[`BIT_P0TX] = port0_tx_irq;
    rawEvent[`BIT_P2RX] = port2_rx_irq;
    rawEvent[`BIT_P2TX] = port2_tx_irq;
    rawEvent[`BIT_HOST] = host_port_irq;
    rawEvent[`BIT_P1RX] = port1_rx_irq;
    rawEvent[`BIT_P1TX] = port1_tx_irq;
    rawEvent[`BIT_DMA4] = dma_ch4_irq;
    rawEvent[`BIT_DMA5] = dma_ch5_irq;
  end

  // New events win over a clear or a grant in the same cycle
  always @* begin
    pending_next = pending_reg & ~pendingClear & ~granted_reg;
    pending_next = pending_next | rawEvent;
  end

  // Fixed priority: reset, NMI, then lowest unmasked bit; trap only when none of these is ready
  always @* begin
    winner = {NUM{1'b0}};
    winOffset = `VEC_RESET;
    winPriority = `PRI_NONE;
    winValid = 1'b0;
    winKind = KIND_MASK;
    if (resetPend_reg) begin
      winOffset = `VEC_RESET;
      winPriority = `PRI_RESET;
      winValid = 1'b1;
      winKind = KIND_RESET;
    end else if (nmiPend_reg) begin
      winOffset = `VEC_NMI;
      winPriority = `PRI_NMI;
      winValid = 1'b1;
      winKind = KIND_NMI;
    end else begin
      for (k = NUM - 1; k >= 0; k = k - 1) begin
        if (pending_reg[k] && mask_reg[k] && globalEnable) begin
          winner = {NUM{1'b0}};
          winner[k] = 1'b1;
          winOffset = vecOf(k);
          winPriority = priOf(k);
          winValid = 1'b1;
        end
      end
      if (!winValid && softPend_reg) begin
        winOffset = softOffset_reg;
        winPriority = `PRI_NONE;
        winValid = 1'b1;
        winKind = KIND_SOFT;
      end
    end
  end

  // Pending flags and their mirror on the outputs
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pending_reg <= `PENDING_RESET;
      pendingFlags <= `PENDING_RESET;
    end else begin
      pending_reg <= pending_next;
      pendingFlags <= pending_next;
    end
  end

  // A mask write reaches the arbiter one cycle later
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      mask_reg <= `MASK_RESET;
      maskFlags <= `MASK_RESET;
    end else if (maskWrite) begin
      mask_reg <= maskWriteData;
      maskFlags <= maskWriteData;
    end
  end

  // Reset and NMI are edge-latched and never masked; a new set beats the ack
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      resetPend_reg <= 1'b0;
      nmiPend_reg <= 1'b0;
    end else begin
      if (ctlFall[0] || soft_reset_trap) begin
        resetPend_reg <= 1'b1;
      end else if (ackNow && kind_reg == KIND_RESET) begin
        resetPend_reg <= 1'b0;
      end
      if (ctlFall[1] || soft_trap_sixteen) begin
        nmiPend_reg <= 1'b1;
      end else if (ackNow && kind_reg == KIND_NMI) begin
        nmiPend_reg <= 1'b0;
      end
    end
  end

  // One trap waits at a time; later ones are dropped until it is taken
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      softPend_reg <= 1'b0;
      softOffset_reg <= `VEC_SOFT_FIRST;
    end else if (ackNow && kind_reg == KIND_SOFT) begin
      softPend_reg <= 1'b0;
    end else if (softAccept) begin
      softPend_reg <= 1'b1;
      softOffset_reg <= softSlot;
    end
  end

  // Winner is frozen until the sequencer acknowledges; no preemption
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      granted_reg <= {NUM{1'b0}};
      kind_reg <= KIND_MASK;
      vectorReq <= 1'b0;
      vectorOffset <= `VEC_RESET;
      vectorPriority <= `PRI_NONE;
    end else begin
      granted_reg <= {NUM{1'b0}};
      case (state_reg)
        ST_IDLE: begin
          if (winValid) begin
            vectorReq <= 1'b1;
            vectorOffset <= winOffset;
            vectorPriority <= winPriority;
            kind_reg <= winKind;
            granted_reg <= winner;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (vectorAck) begin
            vectorReq <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          vectorReq <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // interrupt_vector_priority
`default_nettype wire

/* design/irq_sync_edge.v */
// Two-flop synchroniser with falling-edge detect, one per external pin.
// Assumes pins are asynchronous, active-low requests.
`timescale 1ns/1ps
`default_nettype none
module irq_sync_edge #(
  parameter WIDTH = 4
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [WIDTH-1:0] pinLevel_n,
  output reg [WIDTH-1:0] fallPulse
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] prev_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      always @(posedge clk_sys) begin
        if (!reset_n) begin
          meta_reg[i] <= 1'b1;
          sync_reg[i] <= 1'b1;
          prev_reg[i] <= 1'b1;
          fallPulse[i] <= 1'b0;
        end else begin
          meta_reg[i] <= pinLevel_n[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
          fallPulse[i] <= prev_reg[i] & ~sync_reg[i];
        end
      end
    end
  endgenerate
endmodule // irq_sync_edge
`default_nettype wire

/* design/irq_vector_map.vh */
// Vector offsets, priorities and pending-bit positions of the interrupt
// vector and priority logic. Definitions only; included by bare name.
`ifndef IRQ_VECTOR_MAP_VH
`define IRQ_VECTOR_MAP_VH

// Vector offsets from the vector base, in words
`define VEC_RESET 7'h00
`define VEC_NMI 7'h04
`define VEC_SOFT_FIRST 7'h08
`define VEC_SOFT_LAST 7'h3C
`define SOFT_TRAP_LAST 4'hD
`define VEC_EXT0 7'h40
`define VEC_EXT1 7'h44
`define VEC_EXT2 7'h48
`define VEC_TIMER 7'h4C
`define VEC_P0RX 7'h50
`define VEC_P0TX 7'h54
`define VEC_P2RX 7'h58
`define VEC_P2TX 7'h5C
`define VEC_EXT3 7'h60
`define VEC_HOST 7'h64
`define VEC_P1RX 7'h68
`define VEC_P1TX 7'h6C
`define VEC_DMA4 7'h70
`define VEC_DMA5 7'h74
`define VEC_RSVD_FIRST 7'h78

// Priorities (1 is highest)
`define PRI_RESET 5'h01
`define PRI_NMI 5'h02
`define PRI_EXT0 5'h03
`define PRI_EXT1 5'h04
`define PRI_EXT2 5'h05
`define PRI_TIMER 5'h06
`define PRI_P0RX 5'h07
`define PRI_P0TX 5'h08
`define PRI_P2RX 5'h09
`define PRI_P2TX 5'h0A
`define PRI_EXT3 5'h0B
`define PRI_HOST 5'h0C
`define PRI_P1RX 5'h0D
`define PRI_P1TX 5'h0E
`define PRI_DMA4 5'h0F
`define PRI_DMA5 5'h10
`define PRI_NONE 5'h00

// Maskable source bit positions, in priority order
`define BIT_EXT0 0
`define BIT_EXT1 1
`define BIT_EXT2 2
`define BIT_TIMER 3
`define BIT_P0RX 4
`define BIT_P0TX 5
`define BIT_P2RX 6
`define BIT_P2TX 7
`define BIT_EXT3 8
`define BIT_HOST 9
`define BIT_P1RX 10
`define BIT_P1TX 11
`define BIT_DMA4 12
`define BIT_DMA5 13
`define MASKABLE_COUNT 14

`define PENDING_RESET 14'h0000
`define MASK_RESET 14'h0000

`endif

/* testbench/interrupt_vector_priority_test.sv */
// Self-checking bench: queued vector expectations, sequencer model.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority_test;
  logic clk_sys, reset_n = 0, hw_reset_pin_n = 1, nmi_pin_n = 1;
  logic soft_reset_trap = 0, soft_trap_sixteen = 0, softTrapValid = 0;
  logic [3:0] softTrapNumber = 0, extPin_n = 4'hF, ackDelay = 0;
  logic [13:0] src = 0, maskWriteData = 0, pendingClear = 0, v;
  logic maskWrite = 0, globalEnable = 0, vectorAck, vectorReq;
  logic [6:0] vectorOffset;
  logic [4:0] vectorPriority;
  logic [13:0] pendingFlags, maskFlags;
  logic [11:0] expQ[$];
  logic [31:0] rng = 32'hDEEF7F72;
  int mismatches = 0, cmp_count = 0, b;
  interrupt_vector_priority interrupt_vector_priority_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .hw_reset_pin_n(hw_reset_pin_n),
    .soft_reset_trap(soft_reset_trap), .nmi_pin_n(nmi_pin_n),
    .soft_trap_sixteen(soft_trap_sixteen), .softTrapValid(softTrapValid),
    .softTrapNumber(softTrapNumber), .ext_irq_zero_n(extPin_n[0]),
    .ext_irq_one_n(extPin_n[1]), .ext_irq_two_n(extPin_n[2]),
    .ext_irq_three_n(extPin_n[3]), .timer_irq(src[3]),
    .port0_rx_irq(src[4]), .port0_tx_irq(src[5]), .port2_rx_irq(src[6]),
    .port2_tx_irq(src[7]), .host_port_irq(src[9]), .port1_rx_irq(src[10]),
    .port1_tx_irq(src[11]), .dma_ch4_irq(src[12]), .dma_ch5_irq(src[13]),
    .maskWriteData(maskWriteData), .maskWrite(maskWrite),
    .pendingClear(pendingClear), .globalEnable(globalEnable),
    .vectorAck(vectorAck), .vectorReq(vectorReq),
    .vectorOffset(vectorOffset), .vectorPriority(vectorPriority),
    .pendingFlags(pendingFlags), .maskFlags(maskFlags));
  seq_ack_model seq_ack_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .vectorReq(vectorReq), .ackDelay(ackDelay), .vectorAck(vectorAck));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check_vec(input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR vector exp %h got %h", e, g);
    end
  endtask
  task automatic check_flags(input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR flags exp %h got %h", e, g);
    end
  endtask
  task automatic exp_vec(input int n);
    expQ.push_back({7'h40 + 7'(4 * n), 5'(n + 3)});
  endtask
  task automatic pulse_src(input logic [13:0] p);
    @(posedge clk_sys) src <= p;
    @(posedge clk_sys) src <= 14'h0000;
  endtask
  // Bounded wait, then a quiet spell so stray requests get seen
  task automatic drain;
    for (int i = 0; i < 400 && expQ.size() > 0; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    check_flags(14'h0000, 14'(expQ.size()));
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Each accepted request consumes the oldest expectation
  always @(posedge clk_sys) begin
    if (vectorReq === 1'b1 && vectorAck === 1'b1) begin
      if (expQ.size() == 0)
        check_vec(12'hFFF, {vectorOffset, vectorPriority});
      else
        check_vec(expQ.pop_front(), {vectorOffset, vectorPriority});
    end
  end
  initial begin
    #(20 * 20000);
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1;
    @(posedge clk_sys) #1;
    check_flags(14'h0000, pendingFlags | maskFlags);
    @(posedge clk_sys) globalEnable <= 1;
    pulse_src(14'h0208);
    @(posedge clk_sys) pendingClear <= 14'h0200;
    @(posedge clk_sys) pendingClear <= 14'h0000;
    repeat (3) @(posedge clk_sys);
    #1 check_flags(14'h0008, pendingFlags);
    @(posedge clk_sys) globalEnable <= 0;
    maskWriteData <= 14'h3FFF;
    maskWrite <= 1;
    @(posedge clk_sys) maskWrite <= 0;
    repeat (4) @(posedge clk_sys);
    #1 check_flags(14'h3FFF, maskFlags);
    exp_vec(3);
    @(posedge clk_sys) globalEnable <= 1;
    drain;
    for (b = 0; b < 14; b++) begin
      exp_vec(b);
      if (b < 3 || b == 8) begin
        @(posedge clk_sys) extPin_n[b == 8 ? 3 : b] <= 0;
        repeat (6) @(posedge clk_sys);
        extPin_n <= 4'hF;
      end else pulse_src(14'h0001 << b);
      drain;
    end
    repeat (6) begin
      rng = xs(rng);
      v = rng[13:0] & 14'h3EF8;
      ackDelay <= rng[19:16];
      for (b = 0; b < 14; b++) if (v[b]) exp_vec(b);
      pulse_src(v);
      drain;
    end
    for (b = 0; b < 16; b++) begin
      if (b < 14) expQ.push_back({7'h08 + 7'(4 * b), 5'h00});
      @(posedge clk_sys) softTrapValid <= 1;
      softTrapNumber <= 4'(b);
      @(posedge clk_sys) softTrapValid <= 0;
      drain;
    end
    expQ = '{12'h001, 12'h082, 12'h986, 12'h280};
    @(posedge clk_sys) {soft_reset_trap, soft_trap_sixteen} <= 2'h3;
    {src, softTrapValid, softTrapNumber} <= {14'h0008, 1'b1, 4'h3};
    @(posedge clk_sys) {soft_reset_trap, soft_trap_sixteen} <= 2'h0;
    {src, softTrapValid} <= 15'h0000;
    drain;
    expQ = '{12'h001, 12'h082};
    @(posedge clk_sys) {hw_reset_pin_n, nmi_pin_n} <= 2'h0;
    repeat (6) @(posedge clk_sys);
    {hw_reset_pin_n, nmi_pin_n} <= 2'h3;
    drain;
    // Mid-run reset must drop a held flag and the mask
    @(posedge clk_sys) globalEnable <= 0;
    pulse_src(14'h0008);
    reset_n <= 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1;
    @(posedge clk_sys) #1;
    check_flags(14'h0000, pendingFlags | maskFlags);
    drain;
    wrap_up;
  end
endmodule // interrupt_vector_priority_test
`default_nettype wire

/* testbench/irq_vector_asserts.sv */
// Checker on the interrupt block's request side and flag outputs.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic timer_irq,
  input wire logic vectorAck,
  input wire logic vectorReq,
  input wire logic [6:0] vectorOffset,
  input wire logic [4:0] vectorPriority,
  input wire logic [13:0] pendingFlags,
  input wire logic [13:0] maskFlags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_req_holds: assert property (vectorReq && !vectorAck |=>
    vectorReq && $stable(vectorOffset)) else $error("request moved");
  a_ack_drops: assert property (vectorReq && vectorAck |=>
    !vectorReq) else $error("request kept after ack");
  a_reset_vector: assert property (vectorReq && vectorOffset == 7'h00
    |-> vectorPriority == 5'h01) else $error("reset priority");
  a_timer_vector: assert property (vectorReq && vectorPriority == 5'h06
    |-> vectorOffset == 7'h4C) else $error("timer offset");
  a_host_vector: assert property (vectorReq && vectorPriority == 5'h0C
    |-> vectorOffset == 7'h64) else $error("host offset");
  a_dma_five: assert property (vectorReq && vectorPriority == 5'h10
    |-> vectorOffset == 7'h74) else $error("dma five offset");
  a_soft_slot: assert property (vectorReq && vectorPriority == 5'h00
    |-> vectorOffset inside {[7'h08:7'h3C]} && vectorOffset[1:0] == 2'h0)
    else $error("soft trap slot");
  a_no_reserved: assert property (vectorReq |-> vectorOffset < 7'h78)
    else $error("reserved offset");
  a_timer_latch: assert property (timer_irq |=> pendingFlags[3])
    else $error("timer not pending");
  a_mask_gate: assert property ($rose(vectorReq) && vectorPriority == 5'h06
    |-> $past(maskFlags[3])) else $error("masked timer taken");
endmodule // irq_vector_asserts
bind interrupt_vector_priority irq_vector_asserts irq_vector_asserts_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .timer_irq(timer_irq),
  .vectorAck(vectorAck), .vectorReq(vectorReq), .vectorOffset(vectorOffset),
  .vectorPriority(vectorPriority), .pendingFlags(pendingFlags),
  .maskFlags(maskFlags));
`default_nettype wire

/* testbench/seq_ack_model.sv */
// Sequencer stand-in: accepts each vector request ackDelay+1 cycles after it rises.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module seq_ack_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic vectorReq,
  input wire logic [3:0] ackDelay,
  output logic vectorAck
);
  logic [3:0] waitCount;
  // Ack is one cycle; it drops with the request so nothing is taken twice
  always @(posedge clk_sys) begin
    if (!reset_n || !vectorReq || vectorAck) begin
      vectorAck <= 1'b0;
      waitCount <= 4'h0;
    end else if (waitCount == ackDelay) begin
      vectorAck <= 1'b1;
    end else begin
      waitCount <= waitCount + 4'h1;
    end
  end
endmodule // seq_ack_model
`default_nettype wire
